// *** src/trps_map.svh ***
// Purpose: Named constants for the three-rail power sequencer.
// Assumes: Master clock of 20 MHz (50 ns period).
// Notes: Times are in microseconds; cycle counts derive from them.
`ifndef TRPS_MAP_SVH
`define TRPS_MAP_SVH
`define TRPS_CLK_MHZ 20
`define TRPS_DLY_2MS_US 2000
`define TRPS_DLY_10MS_US 10000
`define TRPS_DLY_30MS_US 30000
`define TRPS_DLY_60MS_US 60000
`define TRPS_DLY_120MS_US 120000
`define TRPS_FIRST_EXTRA_US 400
`define TRPS_SETTLE_US 120000
`define TRPS_CYC(us) ((us) * `TRPS_CLK_MHZ)
`define TRPS_ORDER_DEFAULT 3'h1
`define TRPS_ORDER_MAX 3'h6
`endif

// *** src/trps_pkg.sv ***
// Purpose: Types for the three-rail power sequencer.
// Assumes: Nothing beyond the constant header.
// Notes: Counts are 24 bits, enough for 120.4 ms at 20 MHz.
package trps_pkg;
  typedef enum logic [2:0] {
    TRPS_ST_OFF, TRPS_ST_UP, TRPS_ST_ON, TRPS_ST_SETTLE, TRPS_ST_DOWN
  } trps_state_t;
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } trps_pins_t;
  typedef logic [23:0] trps_cnt_t;
endpackage

// *** src/trps_sequencer.sv ***
// Purpose: Three-rail power sequencer with open-drain release outputs.
// Assumes: Enable arrives asynchronously; sys_rst acts as power-on reset.
// Notes: Order is a strap sampled while sys_rst is high; the delay option is the DLY_US parameter.
`timescale 1ns/1ns
`default_nettype none
`include "trps_map.svh"
module trps_sequencer
  import trps_pkg::*;
#(
  parameter int unsigned DLY_US = `TRPS_DLY_30MS_US,
  parameter int unsigned SETTLE_CYC = `TRPS_CYC(`TRPS_SETTLE_US)
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Enable comparator result and order strap.
  input wire logic enable_in,
  input wire logic [2:0] order_sel,
  // Open-drain release outputs.
  output logic supply_release_out_1,
  output logic supply_release_out_2,
  output logic supply_release_out_3,
  output logic supply_release_oe_1,
  output logic supply_release_oe_2,
  output logic supply_release_oe_3
);
  localparam trps_cnt_t STEP_CYC = trps_cnt_t'(`TRPS_CYC(DLY_US));
  localparam trps_cnt_t FIRST_CYC = trps_cnt_t'(`TRPS_CYC(DLY_US + `TRPS_FIRST_EXTRA_US));
  localparam trps_cnt_t SETTLE = trps_cnt_t'(SETTLE_CYC);

  // Maps an order option and step index to the output that drops at that step.
  function automatic logic [1:0] down_pick(input logic [2:0] ord, input logic [1:0] step);
    logic [5:0] seq;
    seq = 6'h1b;
    case (ord)
      3'h1: seq = {2'h2, 2'h1, 2'h0};
      3'h2: seq = {2'h2, 2'h0, 2'h1};
      3'h3: seq = {2'h1, 2'h2, 2'h0};
      3'h4: seq = {2'h1, 2'h0, 2'h2};
      3'h5: seq = {2'h0, 2'h2, 2'h1};
      3'h6: seq = {2'h0, 2'h1, 2'h2};
      default: seq = {2'h2, 2'h1, 2'h0};
    endcase
    case (step)
      2'h0: down_pick = seq[5:4];
      2'h1: down_pick = seq[3:2];
      default: down_pick = seq[1:0];
    endcase
  endfunction

  logic en_s1_ff, en_s2_ff;
  logic [2:0] ord_ff, nxt_ord;
  trps_state_t st_ff, nxt_st;
  trps_cnt_t cnt_ff, nxt_cnt;
  logic [1:0] step_ff, nxt_step;
  logic [2:0] rel_ff, nxt_rel;
  logic late_ff, nxt_late;
  logic en_prev_ff, nxt_en_prev;
  logic [2:0] ord_s1_ff, ord_s2_ff;
  logic [2:0] oe_ff, nxt_oe;
  logic en_fall;
  trps_pins_t pins;

  // Two-stage synchronisers for the enable level and the order strap pins.
  always_ff @(posedge ref_clk) begin
    en_s1_ff <= enable_in;
    en_s2_ff <= en_s1_ff;
    ord_s1_ff <= order_sel;
    ord_s2_ff <= ord_s1_ff;
    en_prev_ff <= nxt_en_prev;
    ord_ff <= nxt_ord;
  end

  // Edge history and strap capture; an invalid strap falls back to the default order.
  always_comb begin
    nxt_en_prev = sys_rst ? 1'b0 : en_s2_ff;
    nxt_ord = ord_ff;
    if (sys_rst) begin
      if (ord_s2_ff == 3'h0 || ord_s2_ff > `TRPS_ORDER_MAX) begin
        nxt_ord = `TRPS_ORDER_DEFAULT;
      end else begin
        nxt_ord = ord_s2_ff;
      end
    end
  end
  assign en_fall = en_prev_ff & ~en_s2_ff;

  // Sequencer next-state logic.
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_rel = rel_ff;
    nxt_late = late_ff;
    case (st_ff)
      TRPS_ST_OFF: begin
        if (en_s2_ff) begin
          nxt_st = TRPS_ST_UP;
          nxt_cnt = FIRST_CYC;
          nxt_step = 2'h0;
          nxt_late = 1'b0;
        end
      end
      TRPS_ST_UP: begin
        if (!en_s2_ff && step_ff == 2'h0) begin
          nxt_st = TRPS_ST_OFF;
        end else if (en_fall) begin
          nxt_late = 1'b1;
          nxt_cnt = STEP_CYC;
        end else if (cnt_ff <= trps_cnt_t'(1)) begin
          nxt_rel = rel_ff | (3'h1 << step_ff);
          nxt_cnt = STEP_CYC;
          nxt_step = step_ff + 2'h1;
          if (step_ff == 2'h2) begin
            nxt_st = (late_ff || !en_s2_ff) ? TRPS_ST_SETTLE : TRPS_ST_ON;
            nxt_cnt = SETTLE;
            nxt_step = 2'h0;
          end
        end else begin
          nxt_cnt = cnt_ff - trps_cnt_t'(1);
        end
      end
      TRPS_ST_ON: begin
        if (!en_s2_ff) begin
          nxt_st = TRPS_ST_DOWN;
          nxt_cnt = FIRST_CYC;
          nxt_step = 2'h0;
        end
      end
      TRPS_ST_SETTLE: begin
        if (cnt_ff <= trps_cnt_t'(1)) begin
          nxt_st = TRPS_ST_DOWN;
          nxt_cnt = FIRST_CYC;
        end else begin
          nxt_cnt = cnt_ff - trps_cnt_t'(1);
        end
      end
      TRPS_ST_DOWN: begin
        if (cnt_ff <= trps_cnt_t'(1)) begin
          nxt_rel = rel_ff & ~(3'h1 << down_pick(ord_ff, step_ff));
          nxt_cnt = STEP_CYC;
          nxt_step = step_ff + 2'h1;
          if (step_ff == 2'h2) begin
            nxt_st = TRPS_ST_OFF;
            nxt_step = 2'h0;
          end
        end else begin
          nxt_cnt = cnt_ff - trps_cnt_t'(1);
        end
      end
      default: nxt_st = TRPS_ST_OFF;
    endcase
    nxt_oe = ~nxt_rel;
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= TRPS_ST_OFF;
      cnt_ff <= '0;
      step_ff <= 2'h0;
      rel_ff <= 3'h0;
      late_ff <= 1'b0;
      oe_ff <= '1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      rel_ff <= nxt_rel;
      late_ff <= nxt_late;
      oe_ff <= nxt_oe;
    end
  end

  // Open-drain drive: low while held off, high impedance when released.
  assign pins.out = 3'h0;
  assign pins.oe = oe_ff;
  assign supply_release_out_1 = pins.out[0];
  assign supply_release_out_2 = pins.out[1];
  assign supply_release_out_3 = pins.out[2];
  assign supply_release_oe_1 = pins.oe[0];
  assign supply_release_oe_2 = pins.oe[1];
  assign supply_release_oe_3 = pins.oe[2];

  // Checks on sequencing order and timing.
  // The drive check also catches two pins moving in one cycle.
  a_oe_follows_rel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pins.oe == ~rel_ff && pins.out == 3'h0 && $countones(pins.oe ^ $past(pins.oe)) <= 1)
    else $error("Open-drain drive disagrees with release state.");
  a_up_in_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff == TRPS_ST_UP) |-> (rel_ff == 3'h0 || rel_ff == 3'h1 || rel_ff == 3'h3))
    else $error("Power-up release out of order.");
  a_off_until_en: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff == TRPS_ST_OFF && !en_s2_ff) |=> (rel_ff == 3'h0 && st_ff == TRPS_ST_OFF))
    else $error("Output released without enable.");
  a_early_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff == TRPS_ST_UP && step_ff == 2'h0 && !en_s2_ff) |=> st_ff == TRPS_ST_OFF)
    else $error("Early enable drop did not abort.");
  a_first_rel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(rel_ff[0]) |-> cnt_ff == STEP_CYC) else $error("First release reload wrong.");
  a_down_dflt: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ord_ff == 3'h1 && st_ff == TRPS_ST_DOWN && rel_ff == 3'h7) |=>
    (rel_ff == 3'h7 || rel_ff == 3'h3)) else $error("Default power-down not three first.");
  a_down_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ord_ff == 3'h6 && st_ff == TRPS_ST_DOWN && rel_ff == 3'h7) |=>
    (rel_ff == 3'h7 || rel_ff == 3'h6)) else $error("Option six not one first.");
  a_first_longer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff == TRPS_ST_ON && !en_s2_ff) |=> cnt_ff == FIRST_CYC)
    else $error("First power-down delay wrong.");
  a_settle_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff != TRPS_ST_SETTLE ##1 st_ff == TRPS_ST_SETTLE) |-> cnt_ff == SETTLE)
    else $error("Settle wait wrong length.");
  // Strap capture runs only during reset, so this check is not disabled by it.
  a_strap_default: assert property (@(posedge ref_clk)
    (sys_rst && (ord_s2_ff == 3'h0 || ord_s2_ff > `TRPS_ORDER_MAX)) |=>
    ord_ff == `TRPS_ORDER_DEFAULT) else $error("Invalid order strap not mapped to default.");
  c_full_up: cover property (@(posedge ref_clk) st_ff == TRPS_ST_ON);
  c_abort: cover property (@(posedge ref_clk) st_ff == TRPS_ST_UP ##1 st_ff == TRPS_ST_OFF);
  c_settle: cover property (@(posedge ref_clk) st_ff == TRPS_ST_SETTLE);
  c_down_done: cover property (@(posedge ref_clk) st_ff == TRPS_ST_DOWN ##1 st_ff == TRPS_ST_OFF);
endmodule
`default_nettype wire

// *** testbench/trps_rail_model.sv ***
// Purpose: Regulator enable pins seen from the far side of the sequencer.
// Assumes: Each pin has a pull-up inside the regulator.
// Notes: A released pin floats up to the pull-up level, never to the last value.
`timescale 1ns/1ns
`default_nettype none
module trps_rail_model (
  // Design pin drive.
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // Resolved enable levels.
  output logic [2:0] pin_lvl
);
  // Each pin takes the driven value or the pull-up level.
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pin_lvl[k] = pin_oe[k] ? pin_out[k] : 1'h1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the three-rail power sequencer.
// Assumes: Short delay option and short settle time for run length.
// Notes: The driver queues each pin change with its due cycle; a monitor pops and compares.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int STEP = 2 * 20;
  localparam int FIRST = STEP + 8000;
  localparam int SETL = 100;
  localparam int TOL = 8;
  typedef struct {int idx; logic lvl; int at;} trps_note_t;
  logic ref_clk, sys_rst, enable_in;
  logic [2:0] order_sel, pin_out, pin_oe, pin_lvl, prev;
  int cyc = 0, errors = 0, checked = 0, d;
  int dn[6] = '{12'h321, 12'h312, 12'h231, 12'h213, 12'h132, 12'h123};
  trps_note_t q[$];
  trps_note_t n;
  trps_sequencer #(.DLY_US(2), .SETTLE_CYC(SETL)) dut_u (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .enable_in(enable_in), .order_sel(order_sel),
    .supply_release_out_1(pin_out[0]), .supply_release_out_2(pin_out[1]),
    .supply_release_out_3(pin_out[2]), .supply_release_oe_1(pin_oe[0]),
    .supply_release_oe_2(pin_oe[1]), .supply_release_oe_3(pin_oe[2]));
  trps_rail_model rail_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));
  // Compares one value and counts the outcome.
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Notes one expected pin change.
  task automatic note(int idx, logic lvl, int at);
    q.push_back('{idx, lvl, at});
  endtask
  // Waits, bounded, until only n notes are pending.
  task automatic wait_q(int n);
    for (int i = 0; i < 20000 && q.size() > n; i++) @(posedge ref_clk);
    chk("pending", 32'(q.size()), 32'(n));
  endtask
  // Resets with an order strap, powers up, then powers down, optionally cut short.
  task automatic run_order(int ord, bit cut);
    int t;
    sys_rst <= 1'h1;
    // An invalid strap first, then the real one, both inside the reset window.
    order_sel <= ($urandom % 2 == 0) ? 3'h0 : 3'h7;
    repeat (6) @(posedge ref_clk);
    order_sel <= 3'(ord);
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (20 + $urandom % 50) @(posedge ref_clk);
    chk("idle", {29'h0, pin_lvl}, 32'h0);
    if (ord == 1) begin
      enable_in <= 1'h1;
      repeat (100 + $urandom % 500) @(posedge ref_clk);
      enable_in <= 1'h0;
      repeat (20) @(posedge ref_clk);
      chk("abort", {29'h0, pin_lvl}, 32'h0);
    end
    enable_in <= 1'h1;
    t = cyc;
    // A cut run notes only the first release; the others follow the restarted timer.
    for (int k = 0; k < (cut ? 1 : 3); k++) note(k, 1'h1, t + 3 + FIRST + k * STEP);
    if (cut) begin
      wait_q(0);
      repeat (10) @(posedge ref_clk);
      enable_in <= 1'h0;
      note(1, 1'h1, cyc + 3 + STEP);
      note(2, 1'h1, cyc + 3 + 2 * STEP);
      t = cyc + 3 + 2 * STEP + SETL + FIRST;
    end else begin
      wait_q(0);
      repeat (20) @(posedge ref_clk);
      enable_in <= 1'h0;
      t = cyc + 3 + FIRST;
    end
    for (int k = 0; k < 3; k++) note(((dn[ord-1] >> (8 - 4 * k)) & 15) - 1, 1'h0, t + k * STEP);
    wait_q(0);
    repeat (10) @(posedge ref_clk);
  endtask
  // Free-running master clock.
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Counts cycles and matches every pin change outside reset against the oldest note.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= pin_lvl;
    for (int k = 0; k < 3; k++) begin
      if (!sys_rst && pin_lvl[k] !== prev[k]) begin
        if (q.size() == 0) begin
          chk("stray", 32'(k), 32'hff);
        end else begin
          n = q.pop_front();
          d = cyc - n.at;
          chk("pin", 32'(k), 32'(n.idx));
          chk("level", {31'h0, pin_lvl[k]}, {31'h0, n.lvl});
          chk("time", 32'(d <= TOL && d >= -TOL), 32'h1);
        end
      end
    end
  end
  // Main sequence over all six pull-low orders, the last one cut short.
  initial begin
    sys_rst = 1'h1;
    enable_in = 1'h0;
    order_sel = 3'h1;
    void'($urandom(34));
    for (int o = 1; o <= 6; o++) run_order(o, o == 6);
    close_out;
  end
  // Cuts a hang short; a clean run needs just under 99,000 cycles.
  initial begin
    repeat (105000) @(posedge ref_clk);
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
